// [logic/io_carrier_regs.svh]
`ifndef IO_CARRIER_REGS_SVH
`define IO_CARRIER_REGS_SVH

// APB register map, byte addresses of aligned 32-bit words.
`define APB_ADDR_W 12
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define LATCH_OFFSET 12'h008
`define INPUT_OFFSET 12'h00c

// Control register layout and reset value.
`define CTRL_RESET 32'h00000001
`define CTRL_PORT_EN_BIT 0

// Status register layout.
`define STAT_SW_LSB 0
`define STAT_PWR_BIT 8
`define STAT_HOLD_BIT 9
`define STAT_LOSS_BIT 10

// Switch block bit positions; switch n sits at bit n-1, ON reads as one.
`define SW_GUARD_BIT 0
`define SW_DIR_D_BIT 1
`define SW_DIR_C_BIT 2
`define SW_DIR_B_BIT 3
`define SW_DIR_A_BIT 4
`define SW_ADDR_MSB_BIT 5
`define SW_ADDR_MID_BIT 6
`define SW_ADDR_LSB_BIT 7

// Fixed bank codes in the two low address bits.
`define BANK_A_CODE 2'b00
`define BANK_B_CODE 2'b01
`define BANK_C_CODE 2'b10
`define BANK_D_CODE 2'b11

// Pin synchroniser reset value: both host strobes idle high.
`define SYNC_RESET 56'h00600000000000

`endif

// [logic/io_carrier_pkg.sv]
package io_carrier_pkg;
  // Output guard state after loss of external module power.
  typedef enum logic [1:0] {
    GUARD_RUN = 2'b00,
    GUARD_DOWN = 2'b01,
    GUARD_HOLD = 2'b10
  } guard_state_t;
  // One direction bit per bank, bank A at bit 0, one means output.
  typedef logic [3:0] bank_dir_t;
  // Five-bit local address on the host port.
  typedef logic [4:0] port_addr_t;
  // Data of one eight-channel bank.
  typedef logic [7:0] bank_byte_t;
endpackage : io_carrier_pkg

// [logic/bank_latch_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module bank_latch_mem (
  input wire logic clk_in, // System clock.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic clear_in, // Clears every latch.
  input wire logic wr_en_in, // Writes one bank.
  input wire logic [1:0] wr_bank_in, // Bank code to write.
  input wire io_carrier_pkg::bank_byte_t wr_data_in, // Data to write.
  input wire logic [1:0] rd_bank_in, // Bank code to read back.
  output io_carrier_pkg::bank_byte_t rd_data_out, // Registered read data.
  output logic [31:0] latch_out // All latches, bank D on top.
);
  import io_carrier_pkg::*;

  bank_byte_t bank_reg [4]; // The four output latches.
  bank_byte_t bank_next [4]; // Their next values.
  bank_byte_t rd_data_reg; // Read data register.
  bank_byte_t rd_data_next; // Its next value.

  // Clear beats a write, so a write landing during a guarded power loss is dropped.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (clear_in) begin
        bank_next[i] = 8'h00;
      end else if (wr_en_in && (wr_bank_in == 2'(i))) begin
        bank_next[i] = wr_data_in;
      end else begin
        bank_next[i] = bank_reg[i];
      end
    end
    rd_data_next = bank_reg[rd_bank_in];
  end

  // Registers only.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) begin
        bank_reg[i] <= 8'h00;
      end
      rd_data_reg <= 8'h00;
    end else begin
      for (int i = 0; i < 4; i++) begin
        bank_reg[i] <= bank_next[i];
      end
      rd_data_reg <= rd_data_next;
    end
  end

  assign rd_data_out = rd_data_reg;
  assign latch_out = {bank_reg[3], bank_reg[2], bank_reg[1], bank_reg[0]};
endmodule : bank_latch_mem
`default_nettype wire

// [logic/io_carrier_core.sv]
// Contract
// - Guard on, power lost: clear all latches.
// - Guard on: outputs off until host write.
// - Guard off: power loss leaves latches working.
// - Guard off: outputs drive latches on return.
// - Input banks ignore the guard setting.
// - Input data valid right after power returns.
// - Switches 2-5 set banks D, C, B, A.
// - One direction for all eight bank channels.
// - Each bank direction set independently.
// - Bank address: three board bits, two code.
// - Bank codes: A 00, B 01, C 10, D 11.
// - Switch 6 is board address MSB, 8 LSB.
`timescale 1ns/1ps
`default_nettype none
`include "io_carrier_regs.svh"
module io_carrier_core (
  input wire logic clk_in, // System clock, 125 MHz.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic psel_in, // APB select.
  input wire logic penable_in, // APB enable.
  input wire logic pwrite_in, // APB direction, one is write.
  input wire logic [11:0] paddr_in, // APB byte address.
  input wire logic [31:0] pwdata_in, // APB write data.
  output logic [31:0] prdata_out, // APB read data.
  output logic pready_out, // APB ready, always one.
  output logic pslverr_out, // APB error on unmapped address.
  input wire logic [7:0] config_switch_block_in, // Switches 1 to 8 at bits 0 to 7.
  input wire logic ext_power_ok_in, // External module power present.
  input wire io_carrier_pkg::port_addr_t host_addr_in, // Host local address.
  input wire logic host_wr_n_in, // Host write strobe, active low.
  input wire logic host_rd_n_in, // Host read strobe, active low.
  input wire io_carrier_pkg::bank_byte_t host_data_in, // Host data bus, pin level.
  output io_carrier_pkg::bank_byte_t host_data_out, // Host data bus, driven value.
  output logic host_data_oe_out, // Host data bus drive enable.
  input wire logic [31:0] module_data_in, // Input module levels.
  output logic [31:0] module_data_out, // Output module data.
  output logic [31:0] module_oe_out // Output module enables.
);
  import io_carrier_pkg::*;

  // True when the address selects a bank of this board.
  function automatic logic bank_hit(input port_addr_t addr, input logic [2:0] board);
    return addr[4:2] == board;
  endfunction : bank_hit

  // Spreads one direction bit over the eight channels of its bank.
  function automatic logic [31:0] bank_expand(input bank_dir_t dir);
    return {{8{dir[3]}}, {8{dir[2]}}, {8{dir[1]}}, {8{dir[0]}}};
  endfunction : bank_expand

  // Two-stage pin synchroniser over every asynchronous input.
  logic [55:0] sync1_reg; // First stage, read only by the second.
  logic [55:0] sync1_next; // Its next value.
  logic [55:0] sync2_reg; // Second stage, safe to use.
  logic [55:0] sync2_next; // Its next value.

  always_comb begin
    sync1_next = {config_switch_block_in, ext_power_ok_in, host_wr_n_in, host_rd_n_in,
                  host_addr_in, host_data_in, module_data_in};
    sync2_next = sync1_reg;
  end

  // Strobes reset to idle so no false access appears after reset.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_reg <= `SYNC_RESET;
      sync2_reg <= `SYNC_RESET;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  logic [7:0] sw_s; // Synchronised switch block.
  logic pwr_s; // Synchronised power good.
  logic wr_n_s; // Synchronised write strobe.
  logic rd_n_s; // Synchronised read strobe.
  port_addr_t addr_s; // Synchronised address.
  bank_byte_t data_s; // Synchronised host data.
  logic [31:0] mod_s; // Synchronised input modules.
  logic guard; // Power-loss guard switch.
  bank_dir_t dir; // Bank directions, one is output.
  logic [2:0] board; // Board address.

  assign sw_s = sync2_reg[55:48];
  assign pwr_s = sync2_reg[47];
  assign wr_n_s = sync2_reg[46];
  assign rd_n_s = sync2_reg[45];
  assign addr_s = sync2_reg[44:40];
  assign data_s = sync2_reg[39:32];
  assign mod_s = sync2_reg[31:0];
  assign guard = sw_s[`SW_GUARD_BIT];
  // Each bank reads its own switch, so banks never influence each other.
  assign dir = {sw_s[`SW_DIR_D_BIT], sw_s[`SW_DIR_C_BIT],
                sw_s[`SW_DIR_B_BIT], sw_s[`SW_DIR_A_BIT]};
  assign board = {sw_s[`SW_ADDR_MSB_BIT], sw_s[`SW_ADDR_MID_BIT],
                  sw_s[`SW_ADDR_LSB_BIT]};

  // Control, status and edge history registers.
  guard_state_t state_reg; // Output guard state.
  guard_state_t state_next; // Its next value.
  logic [31:0] ctrl_reg; // Control register.
  logic [31:0] ctrl_next; // Its next value.
  logic loss_reg; // Sticky power-loss flag.
  logic loss_next; // Its next value.
  logic pwr_prev_reg; // Power good one cycle ago.
  logic wr_prev_reg; // Write strobe one cycle ago.
  logic [31:0] oe_reg; // Registered module enables.
  logic [31:0] oe_next; // Their next value.
  bank_byte_t data_reg; // Host read data.
  bank_byte_t data_next; // Its next value.
  logic [31:0] prdata_reg; // APB read data.
  logic [31:0] prdata_next; // Its next value.

  logic port_en; // Host port accepted.
  logic wr_pulse; // One-cycle host write, any address.
  logic clear; // Latches held clear.
  logic mem_we; // Latch write enable.
  logic rd_active; // Host reads one of our banks.
  bank_byte_t in_byte; // Input bank byte addressed by the host.
  bank_byte_t mem_rd; // Output latch readback.
  logic [31:0] latch_q; // All output latches.
  logic apb_wr; // APB write access phase.

  assign port_en = ctrl_reg[`CTRL_PORT_EN_BIT];
  // The strobe's falling edge marks a write; address and data must settle
  // before it, since they pass the same two-stage delay as the strobe.
  assign wr_pulse = wr_prev_reg && !wr_n_s && port_en;
  assign clear = guard && !pwr_s;
  // Only our own output banks take data, and never while the guard holds clear.
  assign mem_we = wr_pulse && bank_hit(addr_s, board) && dir[addr_s[1:0]]
                  && (state_reg != GUARD_DOWN) && !clear;
  assign rd_active = !rd_n_s && port_en && bank_hit(addr_s, board);
  assign in_byte = mod_s[{addr_s[1:0], 3'b000} +: 8];
  assign apb_wr = psel_in && penable_in && pwrite_in;

  bank_latch_mem latch_mem (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(clear),
    .wr_en_in(mem_we),
    .wr_bank_in(addr_s[1:0]),
    .wr_data_in(data_s),
    .rd_bank_in(addr_s[1:0]),
    .rd_data_out(mem_rd),
    .latch_out(latch_q)
  );

  // Guard state: DOWN while power is gone, HOLD until the first host write.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      GUARD_RUN: begin
        if (guard && !pwr_s) begin
          state_next = GUARD_DOWN;
        end
      end
      GUARD_DOWN: begin
        if (!guard) begin
          state_next = GUARD_RUN;
        end else if (pwr_s) begin
          state_next = GUARD_HOLD;
        end
      end
      GUARD_HOLD: begin
        if (guard && !pwr_s) begin
          state_next = GUARD_DOWN;
        end else if (!guard || wr_pulse) begin
          state_next = GUARD_RUN;
        end
      end
      default: begin
        state_next = GUARD_RUN; // Unused code recovers to normal running.
      end
    endcase
  end

  // Enables follow the bank switches; with the guard off state stays RUN,
  // so the latched data reappear as soon as power is back.
  always_comb begin
    oe_next = bank_expand(dir) & {32{pwr_s && (state_next == GUARD_RUN)}};
  end

  // Host read data: input banks pass the pins straight through, so data is
  // valid as soon as power is back; output banks read back their latches.
  always_comb begin
    data_next = data_reg;
    if (rd_active) begin
      data_next = dir[addr_s[1:0]] ? mem_rd : in_byte;
    end
  end

  // APB side: control writes, write-one-to-clear of the loss flag.
  always_comb begin
    ctrl_next = ctrl_reg;
    loss_next = loss_reg;
    if (apb_wr && (paddr_in == `CTRL_OFFSET)) begin
      ctrl_next = {31'h0, pwdata_in[`CTRL_PORT_EN_BIT]};
    end
    if (apb_wr && (paddr_in == `STATUS_OFFSET) && pwdata_in[`STAT_LOSS_BIT]) begin
      loss_next = 1'b0;
    end
    // A new loss in the clearing cycle is kept: set wins.
    if (pwr_prev_reg && !pwr_s) begin
      loss_next = 1'b1;
    end
  end

  // Read data is loaded in the setup phase so the access phase needs no wait.
  always_comb begin
    prdata_next = prdata_reg;
    if (psel_in && !penable_in) begin
      case (paddr_in)
        `CTRL_OFFSET: prdata_next = ctrl_reg;
        `STATUS_OFFSET: begin
          prdata_next = 32'h0;
          prdata_next[`STAT_SW_LSB +: 8] = sw_s;
          prdata_next[`STAT_PWR_BIT] = pwr_s;
          prdata_next[`STAT_HOLD_BIT] = (state_reg != GUARD_RUN);
          prdata_next[`STAT_LOSS_BIT] = loss_reg;
        end
        `LATCH_OFFSET: prdata_next = latch_q;
        `INPUT_OFFSET: prdata_next = mod_s;
        default: prdata_next = 32'h0;
      endcase
    end
  end

  // Registers only.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= GUARD_RUN;
      ctrl_reg <= `CTRL_RESET;
      loss_reg <= 1'b0;
      pwr_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b1;
      oe_reg <= 32'h0;
      data_reg <= 8'h00;
      prdata_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      loss_reg <= loss_next;
      pwr_prev_reg <= pwr_s;
      wr_prev_reg <= wr_n_s;
      oe_reg <= oe_next;
      data_reg <= data_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && (paddr_in != `CTRL_OFFSET)
                       && (paddr_in != `STATUS_OFFSET) && (paddr_in != `LATCH_OFFSET)
                       && (paddr_in != `INPUT_OFFSET);
  assign host_data_out = data_reg;
  assign host_data_oe_out = rd_active;
  assign module_data_out = latch_q;
  assign module_oe_out = oe_reg;

  // Checks.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence power_restored_s;
    (guard && !pwr_s) ##1 (guard && pwr_s);
  endsequence

  sequence guard_off_power_s;
    !guard ##1 (!guard && pwr_s);
  endsequence

  loss_clears_a: assert property (guard && !pwr_s |=> latch_q == 32'h0)
    else $error("latches not cleared on power loss");
  return_held_a: assert property (power_restored_s |-> module_oe_out == 32'h0 ##1
                                  module_oe_out == 32'h0)
    else $error("outputs enabled right after power return");
  hold_waits_a: assert property ((state_reg == GUARD_HOLD) && guard && pwr_s
                                 && !wr_pulse |=> module_oe_out == 32'h0)
    else $error("outputs enabled before host write");
  latch_kept_a: assert property (!guard && !pwr_s && !wr_pulse |=> $stable(latch_q))
    else $error("latches changed during power loss");
  drive_return_a: assert property (guard_off_power_s |=>
                                   module_oe_out == bank_expand($past(dir)))
    else $error("outputs not driven after power return");
  input_read_a: assert property (rd_active && !dir[addr_s[1:0]] |=>
                                 host_data_out == $past(in_byte))
    else $error("input bank read data wrong");
  bank_uniform_a: assert property (module_oe_out[31:24] == {8{module_oe_out[24]}}
                                   && module_oe_out[7:0] == {8{module_oe_out[0]}})
    else $error("mixed directions inside a bank");
  bank_input_a: assert property (!dir[3] |=> module_oe_out[31:24] == 8'h00)
    else $error("input bank D driven");
  bank_b_write_a: assert property (wr_pulse && (addr_s == {board, `BANK_B_CODE})
                                   && dir[1] && (state_reg != GUARD_DOWN) && !clear
                                   |=> latch_q[15:8] == $past(data_s))
    else $error("bank B write lost");
  foreign_write_a: assert property (wr_pulse && !clear && (!bank_hit(addr_s, board)
                                    || !dir[addr_s[1:0]]) |=> $stable(latch_q))
    else $error("latch written without address match");
endmodule : io_carrier_core
`default_nettype wire

// [testbench/host_port_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  input wire logic clk_in, // Bench clock.
  input wire logic oe_in, // Carrier drives the data bus.
  input wire io_carrier_pkg::bank_byte_t bus_in, // Data bus pin level.
  output io_carrier_pkg::port_addr_t addr_out, // Local address.
  output logic wr_n_out, // Write strobe, active low.
  output logic rd_n_out, // Read strobe, active low.
  output io_carrier_pkg::bank_byte_t drv_out // Data driven by the host.
);
  import io_carrier_pkg::*;
  // Idle port: strobes high, address and data at a known level.
  initial begin
    addr_out = 5'h00;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    drv_out = 8'h00;
  end
  // One bank write; address and data settle well before the strobe falls.
  task automatic wr(input port_addr_t a, input bank_byte_t d);
    @(posedge clk_in);
    addr_out <= a;
    drv_out <= d;
    repeat (3) @(posedge clk_in);
    wr_n_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    wr_n_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    drv_out <= ~d; // Released bus never keeps showing the last byte.
  endtask : wr
  // One bank read; ok stays low when the carrier never drives.
  task automatic rd(input port_addr_t a, output bank_byte_t d, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk_in);
    addr_out <= a;
    rd_n_out <= 1'b0;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge clk_in);
      ok = (oe_in === 1'b1);
    end
    repeat (2) @(posedge clk_in);
    d = bus_in;
    rd_n_out <= 1'b1;
    repeat (3) @(posedge clk_in);
  endtask : rd
endmodule : host_port_model
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "io_carrier_regs.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module tb;
  import io_carrier_pkg::*;
  // One expected result waiting for the monitor.
  typedef struct {logic [2:0] sel; logic [31:0] val;} note_t;
  note_t notes[$]; // Oldest expectation first.
  event look_ev; // Results are settled and may be compared.
  int tests_run = 0; // Comparisons made.
  int fails = 0; // Mismatches seen.
  int seed = 96; // Fixed seed keeps runs repeatable.
  logic clk_in, rst_n_in, psel, penable, pwrite, pwr, prdy, perr, oe, wr_n, rd_n, rd_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_word, mod_in, mod_out, mod_oe;
  logic [7:0] sw;
  port_addr_t haddr;
  bank_byte_t bus, dout, hdrv, rd_byte;
  logic rd_err;
  // The pin carries whichever party drives it.
  assign bus = oe ? dout : hdrv;
  io_carrier_core uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr),
    .config_switch_block_in(sw), .ext_power_ok_in(pwr), .host_addr_in(haddr),
    .host_wr_n_in(wr_n), .host_rd_n_in(rd_n), .host_data_in(bus), .host_data_out(dout),
    .host_data_oe_out(oe), .module_data_in(mod_in), .module_data_out(mod_out),
    .module_oe_out(mod_oe));
  host_port_model host (.clk_in(clk_in), .oe_in(oe), .bus_in(bus), .addr_out(haddr),
    .wr_n_out(wr_n), .rd_n_out(rd_n), .drv_out(hdrv));
  // 125 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Switch word: guard, directions D to A, board address MSB first.
  function automatic logic [7:0] mk_sw(input logic g, input bank_dir_t d, input logic [2:0] a);
    return {a[0], a[1], a[2], d[0], d[1], d[2], d[3], g};
  endfunction : mk_sw
  // Enables are whole bytes, one per bank.
  function automatic logic [31:0] oe_of(input bank_dir_t d);
    return {{8{d[3]}}, {8{d[2]}}, {8{d[1]}}, {8{d[0]}}};
  endfunction : oe_of
  task automatic note(input logic [2:0] s, input logic [31:0] v);
    notes.push_back('{s, v});
  endtask : note
  // Lets outputs settle off the edge, then wakes the monitor; returns on the
  // next rising edge so that the stimulus after it stays edge-aligned.
  task automatic look;
    #1;
    ->look_ev;
    @(posedge clk_in);
  endtask : look
  task automatic print_verdict;
    $display("Counts: %0d compared, %0d failed", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  // APB transfer held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_in);
      if (prdy === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      print_verdict();
    end
    rd_word = prdata;
    rd_err = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Monitor: each settled result is judged against the oldest note.
  initial begin : monitor
    note_t n;
    forever begin
      @(look_ev);
      while (notes.size() > 0) begin
        n = notes.pop_front();
        case (n.sel)
          3'd0: `CHK(mod_out, n.val)
          3'd1: `CHK(mod_oe, n.val)
          3'd2: `CHK(rd_word, n.val)
          3'd3: `CHK({23'h0, rd_ok, rd_ok ? rd_byte : 8'h00}, n.val[8:0])
          default: `CHK({31'h0, rd_err}, n.val)
        endcase
      end
    end
  end
  initial begin : main
    bank_dir_t dir;
    logic [2:0] board;
    bank_byte_t b;
    logic [31:0] lat;
    logic [31:0] md;
    int i;
    int k;
    rst_n_in = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    sw = 8'h00;
    pwr = 1'b1;
    mod_in = 32'h0;
    lat = 32'h0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    note(3'd0, 32'h0);
    note(3'd1, 32'h0);
    apb(1'b0, `CTRL_OFFSET, 32'h0);
    note(3'd2, `CTRL_RESET);
    look();
    apb(1'b0, 12'h010, 32'h0);
    note(3'd4, 32'h1);
    look();
    $display("Test reset done");
    // Random directions and board addresses; a near-miss board is always refused.
    for (k = 0; k < 4; k++) begin
      dir = 4'($random(seed));
      board = 3'($random(seed));
      md = $random(seed);
      sw <= mk_sw(1'b0, dir, board);
      mod_in <= md;
      repeat (4) @(posedge clk_in);
      for (i = 0; i < 4; i++) begin
        b = 8'($random(seed));
        host.wr({board ^ 3'd5, i[1:0]}, ~b);
        host.wr({board, i[1:0]}, b);
        if (dir[i]) lat[8*i +: 8] = b;
        // Input banks return the pins, output banks read back their latch.
        host.rd({board, i[1:0]}, rd_byte, rd_ok);
        note(3'd3, {23'h0, 1'b1, dir[i] ? b : md[8*i +: 8]});
        look();
      end
      note(3'd0, lat);
      note(3'd1, oe_of(dir));
      look();
      apb(1'b0, `LATCH_OFFSET, 32'h0);
      note(3'd2, lat);
      host.rd({board ^ 3'd2, 2'b00}, rd_byte, rd_ok);
      note(3'd3, 32'h0);
      look();
      // The input word register shows the synchronised module pins.
      apb(1'b0, `INPUT_OFFSET, 32'h0);
      note(3'd2, md);
      look();
    end
    $display("Test addressing done");
    // Guard on: power loss clears, outputs stay off until a write.
    sw <= mk_sw(1'b1, 4'h7, 3'd3);
    md = $random(seed);
    mod_in <= md;
    repeat (4) @(posedge clk_in);
    host.wr(5'b01100, 8'ha5);
    pwr <= 1'b0;
    repeat (6) @(posedge clk_in);
    note(3'd0, 32'h0);
    note(3'd1, 32'h0);
    look();
    // Status during the loss: switches, no power, guard holding, loss flagged.
    lat = 32'h0;
    lat[`STAT_SW_LSB +: 8] = mk_sw(1'b1, 4'h7, 3'd3);
    lat[`STAT_HOLD_BIT] = 1'b1;
    lat[`STAT_LOSS_BIT] = 1'b1;
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    note(3'd2, lat);
    look();
    pwr <= 1'b1;
    repeat (6) @(posedge clk_in);
    host.rd(5'b01111, rd_byte, rd_ok);
    note(3'd3, {23'h0, 1'b1, md[31:24]});
    note(3'd1, 32'h0);
    look();
    // Power is back but the hold stands; writing one clears the loss flag.
    apb(1'b1, `STATUS_OFFSET, 32'h1 << `STAT_LOSS_BIT);
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    lat[`STAT_PWR_BIT] = 1'b1;
    lat[`STAT_LOSS_BIT] = 1'b0;
    note(3'd2, lat);
    look();
    host.wr(5'b01110, 8'hc3);
    note(3'd0, 32'h00c30000);
    note(3'd1, 32'h00ffffff);
    look();
    $display("Test guard on done");
    // Guard off: latches keep working without power and show on return.
    sw <= mk_sw(1'b0, 4'hf, 3'd6);
    repeat (4) @(posedge clk_in);
    pwr <= 1'b0;
    repeat (6) @(posedge clk_in);
    host.wr(5'b11001, 8'h96);
    note(3'd0, 32'h00c39600);
    look();
    pwr <= 1'b1;
    repeat (4) @(posedge clk_in);
    note(3'd1, 32'hffffffff);
    note(3'd0, 32'h00c39600);
    look();
    apb(1'b1, `CTRL_OFFSET, 32'h0);
    host.wr(5'b11000, 8'h77);
    apb(1'b1, `CTRL_OFFSET, 32'h1);
    note(3'd0, 32'h00c39600);
    look();
    $display("Test guard off done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
